//--- rtl/dsdr_pkg.sv
// Constants and types for the debug scan data-register block.
// Contract
// - Separate pass-through, identification, port, bank and abort chains; instruction picks one.
// - Pass-through moves serial in to serial out through one stage.
// - Capture with pass-through selected loads zero into that stage.
// - Pass-through and identification chains do nothing at update; shifted data dropped.
// - Identification capture loads the 32-bit code, shifted out LSB first.
// - Port and bank access chains are both 35 bits, same field format.
// - Access capture loads previous result plus acknowledge 010 OK/FAULT, or a zero result plus 001 WAIT.
// - Access chain shifts LSB first: acknowledge first, result in bits 34..3.
// - OK/FAULT only means finished; the debugger reads status to learn faults.
// - A successful read places the register value in the captured result field.
// - Update after OK/FAULT issues a port or bank register request.
// - read_not_write zero writes write_payload to the addressed register.
// - read_not_write one reads and ignores payload, except pushed-mode bank reads compare it; value comes on next scan.
// - Port register requests use only address bits 3 and 2.
// - Bank register requests combine address bits with the bank select register.
// - Reads pipeline; read buffer register returns the last bank read result.
// - Reading the read buffer register has no side effect.
// - Any sticky flag set discards a bank request; next scan answers OK/FAULT.
// - Pushed modes issue a read, compare with payload, update sticky compare flag.
// - Pushed modes are enabled only by the transfer mode field.
// - A bank transaction stays pending until the access port signals completion.
// - After WAIT, update issues nothing and drops shifted bits.
// - WAIT at capture with overrun detect enabled sets the sticky overrun flag.
// - Instruction 1010 port, 1011 bank, 1110 identification, 1111 and unused pass-through.
`default_nettype none

package dsdr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Chain geometry
	localparam int ACC_LEN = 35;
	localparam int ID_LEN = 32;
	localparam int DATA_LEN = 32;
	localparam int ACC_RNW_BIT = 0;
	localparam int ACC_ADDR_LO = 1;
	localparam int ACC_ADDR_HI = 2;
	localparam int ACC_DATA_LO = 3;
	localparam int ACC_DATA_HI = 34;

	////////////////////////////////////////////////////////////////////////////
	// Instruction codes
	localparam logic [3:0] INSTR_ABORT = 4'h8;
	localparam logic [3:0] INSTR_PORT_ACC = 4'ha;
	localparam logic [3:0] INSTR_BANK_ACC = 4'hb;
	localparam logic [3:0] INSTR_IDENT = 4'he;

	// Acknowledge codes
	localparam logic [2:0] ACK_OK_FAULT = 3'h2;
	localparam logic [2:0] ACK_WAIT = 3'h1;

	////////////////////////////////////////////////////////////////////////////
	// Port register addresses (address bits 3..2)
	localparam logic [1:0] PORT_ADDR_RSVD = 2'h0;
	localparam logic [1:0] PORT_ADDR_CTRL = 2'h1;
	localparam logic [1:0] PORT_ADDR_SELECT = 2'h2;
	localparam logic [1:0] PORT_ADDR_RDBUF = 2'h3;

	// Control/status field positions
	localparam int CTRL_OVR_DETECT = 0;
	localparam int CTRL_STICKY_OVR = 1;
	localparam int CTRL_MODE_LO = 2;
	localparam int CTRL_MODE_HI = 3;
	localparam int CTRL_STICKY_CMP = 4;
	localparam int CTRL_STICKY_ERR = 5;
	localparam int CTRL_BUSY = 6;

	// Transfer mode field values
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_VERIFY = 2'h1;
	localparam logic [1:0] MODE_COMPARE = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [4:0] {
		DSDR_CH_BYPASS = 5'h01,
		DSDR_CH_IDENT = 5'h02,
		DSDR_CH_PORT = 5'h04,
		DSDR_CH_BANK = 5'h08,
		DSDR_CH_ABORT = 5'h10
	} dsdr_chain_t;

	typedef enum logic [1:0] {
		DSDR_ST_IDLE = 2'h1,
		DSDR_ST_BANK_WAIT = 2'h2
	} dsdr_state_t;

	// Request word handed from the link domain to the system domain
	typedef struct packed {
		logic isBank;
		logic readNotWrite;
		logic [1:0] addr;
		logic [DATA_LEN-1:0] payload;
	} dsdr_req_t;

	// Request to the access port
	typedef struct packed {
		logic valid;
		logic write;
		logic [1:0] regAddr;
		logic [DATA_LEN-1:0] bankSelect;
		logic [DATA_LEN-1:0] data;
	} dsdr_bank_req_t;

	// Answer from the access port
	typedef struct packed {
		logic done;
		logic error;
		logic [DATA_LEN-1:0] data;
	} dsdr_bank_rsp_t;

endpackage : dsdr_pkg

`default_nettype wire

//--- rtl/dsdr_scan_core.sv
// Data-register scan chains, acknowledge protocol and request issue across two clocks.
`default_nettype none

module dsdr_scan_core #(
	parameter logic [31:0] IDENT_CODE = 32'h00000001 // Arbitrary neutral value
) (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Link clock domain, driven by the scan state machine on the same clock
	input wire logic tck,
	input wire logic tapRst,
	input wire logic [3:0] instruction,
	input wire logic captureDr,
	input wire logic shiftDr,
	input wire logic updateDr,
	input wire logic debug_serial_in,
	output logic debug_serial_out,
	// Access port side, system clock
	output dsdr_pkg::dsdr_bank_req_t bankReq,
	input wire dsdr_pkg::dsdr_bank_rsp_t bankRsp,
	// Status visible to the system
	output logic [dsdr_pkg::DATA_LEN-1:0] ctrlStatus
);

	////////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic dsdr_pkg::dsdr_chain_t chainSel(input logic [3:0] instr);
		case (instr)
			dsdr_pkg::INSTR_PORT_ACC: chainSel = dsdr_pkg::DSDR_CH_PORT;
			dsdr_pkg::INSTR_BANK_ACC: chainSel = dsdr_pkg::DSDR_CH_BANK;
			dsdr_pkg::INSTR_IDENT: chainSel = dsdr_pkg::DSDR_CH_IDENT;
			dsdr_pkg::INSTR_ABORT: chainSel = dsdr_pkg::DSDR_CH_ABORT;
			default: chainSel = dsdr_pkg::DSDR_CH_BYPASS;
		endcase
	endfunction

	// LSB leaves first, new bit enters at the top
	function automatic logic [dsdr_pkg::ACC_LEN-1:0] shiftAcc(
		input logic [dsdr_pkg::ACC_LEN-1:0] cur, input logic din);
		shiftAcc = {din, cur[dsdr_pkg::ACC_LEN-1:1]};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Link domain state

	typedef struct packed {
		logic bypassBit;
		logic [dsdr_pkg::ID_LEN-1:0] idShift;
		logic [dsdr_pkg::ACC_LEN-1:0] portShift;
		logic [dsdr_pkg::ACC_LEN-1:0] bankShift;
		logic [dsdr_pkg::ACC_LEN-1:0] abortShift;
		logic lastAckOk;
		logic reqTog;
		logic ovrTog;
		logic ackSync1;
		logic ackSync2;
		dsdr_pkg::dsdr_req_t req;
	} dsdr_link_t;

	typedef struct packed {
		dsdr_pkg::dsdr_state_t state;
		logic reqSync1;
		logic reqSync2;
		logic reqSeen;
		logic ovrSync1;
		logic ovrSync2;
		logic ovrSeen;
		logic ackTog;
		logic [dsdr_pkg::DATA_LEN-1:0] result;
		logic [dsdr_pkg::DATA_LEN-1:0] readBuffer;
		logic [dsdr_pkg::DATA_LEN-1:0] bankSelect;
		logic overrunDetect;
		logic [1:0] transferMode;
		logic stickyOverrun;
		logic stickyCompare;
		logic stickyError;
		logic bankValid;
		logic bankWrite;
	} dsdr_sys_t;

	localparam dsdr_link_t LINK_RESET = '{
		bypassBit: 1'b0, idShift: '0, portShift: '0, bankShift: '0, abortShift: '0,
		lastAckOk: 1'b0, reqTog: 1'b0, ovrTog: 1'b0, ackSync1: 1'b0, ackSync2: 1'b0,
		req: '0};

	localparam dsdr_sys_t SYS_RESET = '{
		state: dsdr_pkg::DSDR_ST_IDLE, reqSync1: 1'b0, reqSync2: 1'b0, reqSeen: 1'b0,
		ovrSync1: 1'b0, ovrSync2: 1'b0, ovrSeen: 1'b0, ackTog: 1'b0, result: '0,
		readBuffer: '0, bankSelect: '0, overrunDetect: 1'b0,
		transferMode: dsdr_pkg::MODE_NORMAL, stickyOverrun: 1'b0, stickyCompare: 1'b0,
		stickyError: 1'b0, bankValid: 1'b0, bankWrite: 1'b0};

	dsdr_link_t lnk;
	dsdr_link_t next_lnk;
	dsdr_sys_t sys;
	dsdr_sys_t next_sys;

	dsdr_pkg::dsdr_chain_t sel;
	logic busy;
	logic [dsdr_pkg::ACC_LEN-1:0] accCapture;

	assign sel = chainSel(instruction);
	// A request is outstanding until the returned toggle matches the one sent
	assign busy = lnk.reqTog != lnk.ackSync2;

	////////////////////////////////////////////////////////////////////////////
	// Link domain: capture, shift, update

	always_comb begin
		next_lnk = lnk;
		next_lnk.ackSync1 = sys.ackTog;
		next_lnk.ackSync2 = lnk.ackSync1;
		// The system result is only sampled once the handshake is idle, so it is stable
		if (busy) begin
			accCapture = {{dsdr_pkg::DATA_LEN{1'b0}}, dsdr_pkg::ACK_WAIT};
		end else begin
			accCapture = {sys.result, dsdr_pkg::ACK_OK_FAULT};
		end
		if (captureDr) begin
			case (sel)
				dsdr_pkg::DSDR_CH_IDENT: begin
					next_lnk.idShift = IDENT_CODE;
				end
				dsdr_pkg::DSDR_CH_PORT: begin
					next_lnk.portShift = accCapture;
					next_lnk.lastAckOk = !busy;
					next_lnk.ovrTog = lnk.ovrTog ^ busy;
				end
				dsdr_pkg::DSDR_CH_BANK: begin
					next_lnk.bankShift = accCapture;
					next_lnk.lastAckOk = !busy;
					next_lnk.ovrTog = lnk.ovrTog ^ busy;
				end
				dsdr_pkg::DSDR_CH_ABORT: begin
					next_lnk.abortShift = '0;
				end
				default: begin
					next_lnk.bypassBit = 1'b0;
				end
			endcase
		end else if (shiftDr) begin
			case (sel)
				dsdr_pkg::DSDR_CH_IDENT: begin
					next_lnk.idShift = {debug_serial_in, lnk.idShift[dsdr_pkg::ID_LEN-1:1]};
				end
				dsdr_pkg::DSDR_CH_PORT: begin
					next_lnk.portShift = shiftAcc(lnk.portShift, debug_serial_in);
				end
				dsdr_pkg::DSDR_CH_BANK: begin
					next_lnk.bankShift = shiftAcc(lnk.bankShift, debug_serial_in);
				end
				dsdr_pkg::DSDR_CH_ABORT: begin
					next_lnk.abortShift = shiftAcc(lnk.abortShift, debug_serial_in);
				end
				default: begin
					next_lnk.bypassBit = debug_serial_in;
				end
			endcase
		end else if (updateDr) begin
			// Pass-through, identification and abort chains take no action here
			if ((sel == dsdr_pkg::DSDR_CH_PORT || sel == dsdr_pkg::DSDR_CH_BANK)
				&& lnk.lastAckOk && !busy) begin
				next_lnk.req.isBank = sel == dsdr_pkg::DSDR_CH_BANK;
				if (sel == dsdr_pkg::DSDR_CH_BANK) begin
					next_lnk.req.readNotWrite = lnk.bankShift[dsdr_pkg::ACC_RNW_BIT];
					next_lnk.req.addr =
						lnk.bankShift[dsdr_pkg::ACC_ADDR_HI:dsdr_pkg::ACC_ADDR_LO];
					next_lnk.req.payload =
						lnk.bankShift[dsdr_pkg::ACC_DATA_HI:dsdr_pkg::ACC_DATA_LO];
				end else begin
					next_lnk.req.readNotWrite = lnk.portShift[dsdr_pkg::ACC_RNW_BIT];
					next_lnk.req.addr =
						lnk.portShift[dsdr_pkg::ACC_ADDR_HI:dsdr_pkg::ACC_ADDR_LO];
					next_lnk.req.payload =
						lnk.portShift[dsdr_pkg::ACC_DATA_HI:dsdr_pkg::ACC_DATA_LO];
				end
				next_lnk.reqTog = !lnk.reqTog;
				next_lnk.lastAckOk = 1'b0;
			end
		end
	end

	// Only tapRst clears this side; it must come with sys_rst or the toggles disagree
	always_ff @(posedge tck) begin
		if (tapRst) begin
			lnk <= LINK_RESET;
		end else begin
			lnk <= next_lnk;
		end
	end

	// Serial output is the low stage of the selected chain, so it is a flop
	always_comb begin
		case (sel)
			dsdr_pkg::DSDR_CH_IDENT: debug_serial_out = lnk.idShift[0];
			dsdr_pkg::DSDR_CH_PORT: debug_serial_out = lnk.portShift[0];
			dsdr_pkg::DSDR_CH_BANK: debug_serial_out = lnk.bankShift[0];
			dsdr_pkg::DSDR_CH_ABORT: debug_serial_out = lnk.abortShift[0];
			default: debug_serial_out = lnk.bypassBit;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// System domain: register requests and access port

	logic reqEdge;
	logic ovrEdge;
	logic anySticky;
	logic pushed;
	logic match;

	// Edges of the two toggles, each seen only after two synchroniser stages
	assign reqEdge = sys.reqSync2 != sys.reqSeen;
	assign ovrEdge = sys.ovrSync2 != sys.ovrSeen;
	// One sticky flag is enough to abandon bank requests until the debugger clears it
	assign anySticky = sys.stickyOverrun | sys.stickyCompare | sys.stickyError;
	assign pushed = sys.transferMode != dsdr_pkg::MODE_NORMAL;
	// The payload holds still while a bank request is outstanding, so comparing here is safe
	assign match = bankRsp.data == lnk.req.payload;

	always_comb begin
		ctrlStatus = '0;
		ctrlStatus[dsdr_pkg::CTRL_OVR_DETECT] = sys.overrunDetect;
		ctrlStatus[dsdr_pkg::CTRL_STICKY_OVR] = sys.stickyOverrun;
		ctrlStatus[dsdr_pkg::CTRL_MODE_HI:dsdr_pkg::CTRL_MODE_LO] = sys.transferMode;
		ctrlStatus[dsdr_pkg::CTRL_STICKY_CMP] = sys.stickyCompare;
		ctrlStatus[dsdr_pkg::CTRL_STICKY_ERR] = sys.stickyError;
		ctrlStatus[dsdr_pkg::CTRL_BUSY] = sys.state == dsdr_pkg::DSDR_ST_BANK_WAIT;
	end

	// Address and data fields come straight from link flops: they hold still while busy
	always_comb begin
		bankReq.valid = sys.bankValid;
		bankReq.write = sys.bankWrite;
		bankReq.regAddr = lnk.req.addr;
		bankReq.bankSelect = sys.bankSelect;
		bankReq.data = lnk.req.payload;
	end

	always_comb begin
		next_sys = sys;
		next_sys.reqSync1 = lnk.reqTog;
		next_sys.reqSync2 = sys.reqSync1;
		next_sys.ovrSync1 = lnk.ovrTog;
		next_sys.ovrSync2 = sys.ovrSync1;
		next_sys.ovrSeen = sys.ovrSync2;
		// lnk.req changed at the same tck edge as reqTog, so it has long settled when
		// the toggle leaves the second synchroniser stage
		case (sys.state)
			dsdr_pkg::DSDR_ST_IDLE: begin
				if (reqEdge) begin
					next_sys.reqSeen = sys.reqSync2;
					if (!lnk.req.isBank) begin
						next_sys.ackTog = !sys.ackTog;
						if (!lnk.req.readNotWrite) begin
							case (lnk.req.addr)
								dsdr_pkg::PORT_ADDR_CTRL: begin
									next_sys.overrunDetect =
										lnk.req.payload[dsdr_pkg::CTRL_OVR_DETECT];
									next_sys.transferMode = lnk.req.payload[
										dsdr_pkg::CTRL_MODE_HI:dsdr_pkg::CTRL_MODE_LO];
									// Sticky flags clear by writing one
									if (lnk.req.payload[dsdr_pkg::CTRL_STICKY_OVR]) begin
										next_sys.stickyOverrun = 1'b0;
									end
									if (lnk.req.payload[dsdr_pkg::CTRL_STICKY_CMP]) begin
										next_sys.stickyCompare = 1'b0;
									end
									if (lnk.req.payload[dsdr_pkg::CTRL_STICKY_ERR]) begin
										next_sys.stickyError = 1'b0;
									end
								end
								dsdr_pkg::PORT_ADDR_SELECT: begin
									next_sys.bankSelect = lnk.req.payload;
								end
								default: begin
								end
							endcase
						end else begin
							case (lnk.req.addr)
								dsdr_pkg::PORT_ADDR_CTRL: next_sys.result = ctrlStatus;
								dsdr_pkg::PORT_ADDR_SELECT: next_sys.result = sys.bankSelect;
								dsdr_pkg::PORT_ADDR_RDBUF: begin
									next_sys.result = sys.readBuffer;
								end
								default: next_sys.result = '0;
							endcase
						end
					end else if (anySticky) begin
						next_sys.ackTog = !sys.ackTog;
					end else begin
						next_sys.state = dsdr_pkg::DSDR_ST_BANK_WAIT;
						next_sys.bankValid = 1'b1;
						// Pushed modes always read; the caller shifts a write
						next_sys.bankWrite = !lnk.req.readNotWrite && !pushed;
					end
				end
			end
			dsdr_pkg::DSDR_ST_BANK_WAIT: begin
				if (bankRsp.done) begin
					next_sys.state = dsdr_pkg::DSDR_ST_IDLE;
					next_sys.bankValid = 1'b0;
					next_sys.ackTog = !sys.ackTog;
					// Result kept even on a write; the debugger ignores it then
					next_sys.result = bankRsp.data;
					if (!sys.bankWrite) begin
						next_sys.readBuffer = bankRsp.data;
					end
					if (bankRsp.error) begin
						next_sys.stickyError = 1'b1;
					end
					// Compare flags a hit, verify flags a miss; a mode of 11 sets nothing
					if (sys.transferMode == dsdr_pkg::MODE_COMPARE && match) begin
						next_sys.stickyCompare = 1'b1;
					end
					if (sys.transferMode == dsdr_pkg::MODE_VERIFY && !match) begin
						next_sys.stickyCompare = 1'b1;
					end
				end
			end
			default: begin
				next_sys.state = dsdr_pkg::DSDR_ST_IDLE;
				next_sys.bankValid = 1'b0;
			end
		endcase
		// After the case, so a set beats a clear in the same cycle
		if (ovrEdge && sys.overrunDetect) begin
			next_sys.stickyOverrun = 1'b1;
		end
	end

	// The system side is cleared by sys_rst alone
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sys <= SYS_RESET;
		end else begin
			sys <= next_sys;
		end
	end

endmodule // dsdr_scan_core

`default_nettype wire

//--- dv/dsdr_scan_core_sva.sv
// Concurrent checks on the ports of the debug scan data-register block.
`default_nettype none
module dsdr_scan_core_sva #(
	parameter logic [31:0] IDENT_CODE = 32'h00000001 // Arbitrary neutral value
) (
	// System side
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire dsdr_pkg::dsdr_bank_req_t bankReq,
	input wire dsdr_pkg::dsdr_bank_rsp_t bankRsp,
	input wire logic [dsdr_pkg::DATA_LEN-1:0] ctrlStatus,
	// Link side
	input wire logic tck,
	input wire logic tapRst,
	input wire logic [3:0] instruction,
	input wire logic captureDr,
	input wire logic shiftDr,
	input wire logic updateDr,
	input wire logic debug_serial_in,
	input wire logic debug_serial_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic selAcc;
	logic selBypass;
	assign selAcc = instruction inside {dsdr_pkg::INSTR_PORT_ACC, dsdr_pkg::INSTR_BANK_ACC};
	assign selBypass = !selAcc
		&& !(instruction inside {dsdr_pkg::INSTR_IDENT, dsdr_pkg::INSTR_ABORT});
	////////////////////////////////////////////////////////////////////////////
	sequence s_accHead;
		captureDr && selAcc ##1 shiftDr [*2];
	endsequence
	property p_ack_code;
		@(posedge tck) disable iff (tapRst) s_accHead |=> {debug_serial_out,
			$past(debug_serial_out), $past(debug_serial_out, 2)} inside {3'h2, 3'h1};
	endproperty
	a_ack_code: assert property (p_ack_code) else $error("Bad acknowledge code");
	property p_bypass_zero;
		@(posedge tck) disable iff (tapRst) captureDr && selBypass |=> !debug_serial_out;
	endproperty
	a_bypass_zero: assert property (p_bypass_zero) else $error("Bypass not zero");
	property p_bypass_delay;
		@(posedge tck) disable iff (tapRst)
		shiftDr && selBypass |=> debug_serial_out == $past(debug_serial_in);
	endproperty
	a_bypass_delay: assert property (p_bypass_delay) else $error("Bypass delay wrong");
	property p_ident_lsb;
		@(posedge tck) disable iff (tapRst)
		captureDr && instruction == dsdr_pkg::INSTR_IDENT |=> debug_serial_out == IDENT_CODE[0];
	endproperty
	a_ident_lsb: assert property (p_ident_lsb) else $error("Ident bit 0 wrong");
	property p_no_update;
		@(posedge tck) disable iff (tapRst) updateDr && !selAcc |=> $stable(debug_serial_out);
	endproperty
	a_no_update: assert property (p_no_update) else $error("Update changed output");
	property p_req_hold;
		@(posedge clk_sys) disable iff (sys_rst)
		bankReq.valid && !bankRsp.done |=> bankReq.valid && $stable(bankReq);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("Request not held");
	property p_req_release;
		@(posedge clk_sys) disable iff (sys_rst) bankReq.valid && bankRsp.done |=> !bankReq.valid;
	endproperty
	a_req_release: assert property (p_req_release) else $error("Request kept");
	property p_sticky_drop;
		@(posedge clk_sys) disable iff (sys_rst) $rose(bankReq.valid) |->
			$past(ctrlStatus[5:4]) == 2'h0 && !$past(ctrlStatus[1]);
	endproperty
	a_sticky_drop: assert property (p_sticky_drop) else $error("Request with sticky");
	property p_pushed_read;
		@(posedge clk_sys) disable iff (sys_rst)
		$rose(bankReq.valid) && ctrlStatus[3:2] != 2'h0 |-> !bankReq.write;
	endproperty
	a_pushed_read: assert property (p_pushed_read) else $error("Pushed wrote");
endmodule // dsdr_scan_core_sva
`default_nettype wire

//--- dv/dsdr_ap_model.sv
// Access port stand-in: register file with adjustable answer delay and fault injection.
`default_nettype none
module dsdr_ap_model (
	// System clock
	input wire logic clk_sys,
	// Request and answer
	input wire dsdr_pkg::dsdr_bank_req_t bankReq,
	output var dsdr_pkg::dsdr_bank_rsp_t bankRsp,
	// Behaviour controls
	input wire logic [7:0] apDelay,
	input wire logic errOn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] regFile [4] = '{default: 32'h0};
	logic [7:0] waitCnt = 8'h0;
	logic served = 1'b0;
	initial bankRsp = '0;
	// Data toggles between answers so stale read data never looks fresh
	always @(negedge clk_sys) begin
		bankRsp.done <= 1'b0;
		bankRsp.error <= 1'b0;
		bankRsp.data <= ~bankRsp.data;
		if (!bankReq.valid) begin
			waitCnt <= 8'h0;
			served <= 1'b0;
		end else if (!served && waitCnt < apDelay) begin
			waitCnt <= waitCnt + 8'h1;
		end else if (!served) begin
			served <= 1'b1;
			bankRsp.done <= 1'b1;
			bankRsp.error <= errOn;
			if (bankReq.write)
				regFile[bankReq.regAddr] <= bankReq.data;
			// Bank select folded into read data so addressing through it shows
			bankRsp.data <= bankReq.write ? ~bankReq.data :
				regFile[bankReq.regAddr] ^ bankReq.bankSelect;
		end
	end
endmodule // dsdr_ap_model
`default_nettype wire

//--- dv/dsdr_scan_core_bench.sv
// Self-checking bench for the debug scan data-register block.
`default_nettype none
module dsdr_scan_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] IDENT_CODE = 32'h5a5ac3c3; // Arbitrary value
	localparam logic [31:0] SEL = 32'h000000f0;
	localparam logic [31:0] DA = 32'h1234abcd;
	localparam logic [31:0] DB = 32'h0f0f5555;
	localparam logic [2:0] OK = dsdr_pkg::ACK_OK_FAULT;
	localparam logic [3:0] PA = dsdr_pkg::INSTR_PORT_ACC;
	localparam logic [3:0] BA = dsdr_pkg::INSTR_BANK_ACC;
	logic clk_sys, sys_rst, tck, tapRst, captureDr, shiftDr, updateDr;
	logic debug_serial_in, debug_serial_out, errOn;
	logic [3:0] instruction;
	logic [7:0] apDelay;
	logic [31:0] ctrlStatus, res;
	logic [34:0] dout;
	logic [2:0] ack;
	logic [3:0] bypassIr [4] = '{4'hf, 4'h9, 4'hc, 4'h0};
	dsdr_pkg::dsdr_bank_req_t bankReq;
	dsdr_pkg::dsdr_bank_rsp_t bankRsp;
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	int i;
	dsdr_scan_core #(.IDENT_CODE(IDENT_CODE)) i_dsdr_scan_core (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .tck(tck), .tapRst(tapRst), .instruction(instruction),
		.captureDr(captureDr), .shiftDr(shiftDr), .updateDr(updateDr),
		.debug_serial_in(debug_serial_in), .debug_serial_out(debug_serial_out),
		.bankReq(bankReq), .bankRsp(bankRsp), .ctrlStatus(ctrlStatus));
	dsdr_ap_model i_dsdr_ap_model (.clk_sys(clk_sys), .bankReq(bankReq), .bankRsp(bankRsp),
		.apDelay(apDelay), .errOn(errOn));
	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Link clock offset so its edges drift against the system clock
	initial begin
		tck = 1'b0;
		#7;
		forever #32 tck = ~tck;
	end
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			close_out();
		end
	end
	task automatic check(input logic [34:0] seen, input logic [34:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One capture, len shifts, one update, then idle so the request can finish
	task automatic scan(input logic [3:0] ir, input logic [34:0] din, input int len);
		@(negedge tck);
		instruction = ir;
		captureDr = 1'b1;
		@(negedge tck);
		captureDr = 1'b0;
		shiftDr = 1'b1;
		for (int k = 0; k < len; k++) begin
			dout[k] = debug_serial_out;
			debug_serial_in = din[k];
			@(negedge tck);
		end
		shiftDr = 1'b0;
		updateDr = 1'b1;
		@(negedge tck);
		updateDr = 1'b0;
		repeat (6) @(negedge tck);
	endtask
	// Expected acknowledge of zero skips its comparison
	task automatic acc(input logic [3:0] ir, input logic read_not_write, input logic [1:0] a,
		input logic [31:0] d, input logic [2:0] expAck);
		scan(ir, {d, a, read_not_write}, 35);
		ack = dout[2:0];
		res = dout[34:3];
		if (expAck != 3'h0)
			check(ack, expAck);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		{captureDr, shiftDr, updateDr, debug_serial_in, errOn} = 5'h0;
		instruction = 4'hf;
		apDelay = 8'h00;
		sys_rst = 1'b1;
		tapRst = 1'b1;
		repeat (6) @(negedge clk_sys);
		sys_rst = 1'b0;
		@(negedge tck);
		tapRst = 1'b0;
		repeat (2) begin
			scan(dsdr_pkg::INSTR_IDENT, 35'h0, 32);
			check(dout[31:0], IDENT_CODE);
		end
		foreach (bypassIr[j]) begin
			scan(bypassIr[j], 35'h2d, 8);
			check(dout[7:0], 8'h5a);
		end
		// Abort chain captures zero and ignores what was shifted in before
		repeat (2) begin
			scan(dsdr_pkg::INSTR_ABORT, 35'h7ffffffff, 35);
			check(dout, 35'h0);
		end
		// Writes return undefined results, so no scan that follows a write has its result compared
		acc(PA, 1'b0, dsdr_pkg::PORT_ADDR_CTRL, 32'h1, OK);
		check(ctrlStatus, 32'h1);
		acc(PA, 1'b0, dsdr_pkg::PORT_ADDR_SELECT, SEL, OK);
		acc(PA, 1'b1, dsdr_pkg::PORT_ADDR_CTRL, 32'h0, OK);
		acc(PA, 1'b1, dsdr_pkg::PORT_ADDR_SELECT, 32'h0, OK);
		check(res, 32'h1);
		acc(BA, 1'b0, 2'h1, DA, OK);
		check(res, SEL);
		acc(BA, 1'b0, 2'h2, DB, OK);
		acc(BA, 1'b1, 2'h1, 32'h0, OK);
		acc(BA, 1'b1, 2'h2, 32'h0, OK);
		check(res, DA ^ SEL);
		repeat (2) begin
			acc(PA, 1'b1, dsdr_pkg::PORT_ADDR_RDBUF, 32'h0, OK);
			check(res, DB ^ SEL);
		end
		// Slow answer: the next scan must wait and flag the overrun
		apDelay = 8'hc8;
		acc(BA, 1'b0, 2'h3, 32'h0, OK);
		acc(BA, 1'b0, 2'h3, 32'hdead0000, dsdr_pkg::ACK_WAIT);
		check(ctrlStatus[1], 1'b1);
		for (i = 0; i < 20 && ack !== OK; i++)
			acc(BA, 1'b0, 2'h3, 32'hdead0000, 3'h0);
		check(ack, OK);
		apDelay = 8'h00;
		acc(PA, 1'b0, dsdr_pkg::PORT_ADDR_CTRL, 32'h3, OK);
		check(ctrlStatus, 32'h1);
		acc(BA, 1'b1, 2'h3, 32'h0, OK);
		acc(PA, 1'b1, dsdr_pkg::PORT_ADDR_RDBUF, 32'h0, OK);
		check(res, SEL);
		// Compare on a match, then verify on a mismatch; both raise the flag
		for (i = 0; i < 2; i++) begin
			acc(PA, 1'b0, dsdr_pkg::PORT_ADDR_CTRL, i ? 32'h5 : 32'h9, OK);
			acc(BA, 1'b0, 2'h1, i ? 32'h0 : DA ^ SEL, OK);
			check(ctrlStatus[4], 1'b1);
			acc(PA, 1'b0, dsdr_pkg::PORT_ADDR_CTRL, 32'h11, OK);
			check(ctrlStatus, 32'h1);
		end
		errOn = 1'b1;
		acc(BA, 1'b1, 2'h1, 32'h0, OK);
		errOn = 1'b0;
		acc(PA, 1'b1, dsdr_pkg::PORT_ADDR_CTRL, 32'h0, OK);
		check(ctrlStatus[5], 1'b1);
		acc(PA, 1'b0, dsdr_pkg::PORT_ADDR_CTRL, 32'h21, OK);
		check(res, 32'h21);
		check(ctrlStatus, 32'h1);
		close_out();
	end
endmodule // dsdr_scan_core_bench
bind dsdr_scan_core dsdr_scan_core_sva #(.IDENT_CODE(IDENT_CODE)) i_dsdr_scan_core_sva (
	.clk_sys, .sys_rst, .bankReq, .bankRsp, .ctrlStatus, .tck, .tapRst, .instruction,
	.captureDr, .shiftDr, .updateDr, .debug_serial_in, .debug_serial_out);
`default_nettype wire
